//--- src/task_file_pkg.sv
/*
 * Constants for the task-file register bank: register addresses,
 * field positions, values after reset and timing counts.
 * Assumes a single 125 MHz clock in the surrounding device.
 */
package task_file_pkg;

    // Register selects: {cs0_n, cs1_n, da[2:0]}
    localparam logic [4:0] SEL_DATA     = 5'h08;
    localparam logic [4:0] SEL_ERR_FEAT = 5'h09;
    localparam logic [4:0] SEL_COUNT    = 5'h0a;
    localparam logic [4:0] SEL_SECTOR   = 5'h0b;
    localparam logic [4:0] SEL_CYL_LO   = 5'h0c;
    localparam logic [4:0] SEL_CYL_HI   = 5'h0d;
    localparam logic [4:0] SEL_UNIT     = 5'h0e;
    localparam logic [4:0] SEL_STAT_CMD = 5'h0f;
    localparam logic [4:0] SEL_ALT_CTRL = 5'h16;
    localparam logic [4:0] SEL_ADDR_RPT = 5'h17;

    // Interface control bits
    localparam int SOFT_RESET_POS  = 2;
    localparam int INT_DISABLE_POS = 1;

    // Unit and head select fields
    localparam int LINEAR_POS = 6;
    localparam int UNIT_POS   = 4;
    localparam logic [7:0] UNIT_FIXED_ONES = 8'ha0;

    // Status bit positions
    localparam int BUSY_POS = 7;
    localparam int DRQ_POS  = 3;
    localparam int ERR_POS  = 0;

    // Error bits that read zero after a command end (5 and 3)
    localparam logic [7:0] FAULT_MASK = 8'hd7;

    // Values after reset
    localparam logic [7:0] RST_COUNT  = 8'h01;
    localparam logic [7:0] RST_SECTOR = 8'h01;
    localparam logic [7:0] RST_CYL    = 8'h00;
    localparam logic [7:0] RST_UNIT   = 8'ha0;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_DIAG   = 8'h01;

    // Minimum soft-reset hold the host keeps, and its cycle count
    localparam int CLK_MHZ        = 125;
    localparam int SOFT_RESET_BIT_HOLD_US   = 5;
    localparam int SOFT_RESET_BIT_HOLD_CYC  = SOFT_RESET_BIT_HOLD_US * CLK_MHZ;

endpackage

//--- src/disk_task_file_registers.sv
/*
 * Task-file register bank of a disk drive, seen from the host port.
 * Assumes host strobes are synchronous to clock_i and each strobe is
 * one cycle long; the drive core supplies status, position and data.
 */
`timescale 1ns/1ps
module disk_task_file_registers
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Host register port
    input  wire logic        cs0_n_i,
    input  wire logic        cs1_n_i,
    input  wire logic [2:0]  da_i,
    input  wire logic        rd_strobe_i,
    input  wire logic        wr_strobe_i,
    input  wire logic [15:0] host_data_i,
    output logic      [15:0] host_data_o,
    output logic      [15:0] host_data_oe_o,
    output logic             host_intrq_o,
    // Drive core: identity and status
    input  wire logic        unit_id_i,
    input  wire logic [7:0]  core_status_i,
    input  wire logic        core_irq_i,
    input  wire logic        write_gate_n_i,
    // Drive core: command handshake
    output logic             cmd_start_o,
    output logic [7:0]       cmd_code_o,
    output logic [7:0]       cmd_param_o,
    output logic [8:0]       sector_total_o,
    output logic             linear_mode_o,
    output logic             soft_reset_o,
    input  wire logic        cmd_done_i,
    input  wire logic        diag_done_i,
    input  wire logic [7:0]  end_fault_i,
    input  wire logic [7:0]  end_remaining_i,
    input  wire logic [7:0]  end_sector_i,
    input  wire logic [7:0]  end_cyl_lo_i,
    input  wire logic [7:0]  end_cyl_hi_i,
    input  wire logic [3:0]  end_head_i,
    // Drive core: data word path
    input  wire logic        ecc_byte_i,
    input  wire logic [15:0] core_rd_data_i,
    output logic      [15:0] core_wr_data_o,
    output logic             core_wr_o,
    output logic             core_rd_o
);

////////////////////////////////////////////////////////////////////////

    logic [4:0]  sel;
    logic        rd_hit;
    logic        wr_hit;
    logic [7:0]  ctrl;
    logic [7:0]  unit_head;
    logic [7:0]  count;
    logic [7:0]  sector;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [7:0]  feature;
    logic [7:0]  command;
    logic [7:0]  fault;
    logic        irq_pend;
    logic        start;
    logic [15:0] wdata;
    logic        wstb;
    logic [7:0]  next_ctrl;
    logic [7:0]  next_unit_head;
    logic [7:0]  next_count;
    logic [7:0]  next_sector;
    logic [7:0]  next_cyl_lo;
    logic [7:0]  next_cyl_hi;
    logic [7:0]  next_feature;
    logic [7:0]  next_command;
    logic [7:0]  next_fault;
    logic        next_irq_pend;
    logic        next_start;
    logic [15:0] next_wdata;
    logic        next_wstb;
    logic        dev_reset;
    logic        selected;
    logic        data_ok;
    logic [15:0] rd_mux;
    logic [15:0] rd_oe;

    // Data lanes: ECC bytes use only the low lane
    function automatic logic [15:0] lane_mask(input logic ecc);
        lane_mask = ecc ? 16'h00ff : 16'hffff;
    endfunction

    assign sel    = {cs0_n_i, cs1_n_i, da_i};
    assign rd_hit = rd_strobe_i;
    assign wr_hit = wr_strobe_i;
    assign dev_reset = rst_i | ctrl[task_file_pkg::SOFT_RESET_POS];
    assign selected  = (unit_head[task_file_pkg::UNIT_POS] == unit_id_i);
    assign data_ok   = core_status_i[task_file_pkg::DRQ_POS];

////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_ctrl      = ctrl;
        next_unit_head = unit_head;
        next_count     = count;
        next_sector    = sector;
        next_cyl_lo    = cyl_lo;
        next_cyl_hi    = cyl_hi;
        next_feature   = feature;
        next_command   = command;
        next_fault     = fault;
        next_irq_pend  = irq_pend;
        next_start     = 1'b0;
        next_wdata     = wdata;
        next_wstb      = 1'b0;
        // Command end reloads position; host writes come after, so a
        // same-cycle write still lands on top of it
        if (cmd_done_i)
        begin
            next_count  = end_remaining_i;
            next_sector = end_sector_i;
            next_cyl_lo = end_cyl_lo_i;
            next_cyl_hi = end_cyl_hi_i;
            next_unit_head[3:0] = end_head_i;
            next_fault  = end_fault_i & task_file_pkg::FAULT_MASK;
        end
        if (diag_done_i)
        begin
            next_fault = end_fault_i;
        end
        // Acknowledge only from primary status; the set wins the clear
        if (rd_hit && sel == task_file_pkg::SEL_STAT_CMD)
        begin
            next_irq_pend = 1'b0;
        end
        if (core_irq_i)
        begin
            next_irq_pend = 1'b1;
        end
        if (wr_hit)
        begin
            case (sel)
                task_file_pkg::SEL_DATA:
                begin
                    next_wdata = host_data_i & lane_mask(ecc_byte_i);
                    next_wstb  = 1'b1;
                end
                task_file_pkg::SEL_ERR_FEAT: next_feature = host_data_i[7:0];
                task_file_pkg::SEL_COUNT:    next_count   = host_data_i[7:0];
                task_file_pkg::SEL_SECTOR:   next_sector  = host_data_i[7:0];
                task_file_pkg::SEL_CYL_LO:   next_cyl_lo  = host_data_i[7:0];
                task_file_pkg::SEL_CYL_HI:   next_cyl_hi  = host_data_i[7:0];
                task_file_pkg::SEL_UNIT:
                    next_unit_head = host_data_i[7:0]
                                   | task_file_pkg::UNIT_FIXED_ONES;
                task_file_pkg::SEL_STAT_CMD:
                begin
                    next_command = host_data_i[7:0];
                    next_start   = 1'b1;
                end
                task_file_pkg::SEL_ALT_CTRL: next_ctrl = host_data_i[7:0];
                default: ;
            endcase
        end
    end

    // Soft reset clears everything except the control register itself,
    // so the host can release it again
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ctrl <= task_file_pkg::RST_CTRL;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
        if (dev_reset)
        begin
            unit_head <= task_file_pkg::RST_UNIT;
            count     <= task_file_pkg::RST_COUNT;
            sector    <= task_file_pkg::RST_SECTOR;
            cyl_lo    <= task_file_pkg::RST_CYL;
            cyl_hi    <= task_file_pkg::RST_CYL;
            feature   <= 8'h00;
            command   <= 8'h00;
            fault     <= task_file_pkg::RST_DIAG;
            irq_pend  <= 1'b0;
            start     <= 1'b0;
            wdata     <= 16'h0000;
            wstb      <= 1'b0;
        end
        else
        begin
            unit_head <= next_unit_head;
            count     <= next_count;
            sector    <= next_sector;
            cyl_lo    <= next_cyl_lo;
            cyl_hi    <= next_cyl_hi;
            feature   <= next_feature;
            command   <= next_command;
            fault     <= next_fault;
            irq_pend  <= next_irq_pend;
            start     <= next_start;
            wdata     <= next_wdata;
            wstb      <= next_wstb;
        end
    end

////////////////////////////////////////////////////////////////////////

    // Read mux; busy makes every register return status
    always_comb
    begin
        rd_mux = 16'h0000;
        rd_oe  = 16'h00ff;
        case (sel)
            task_file_pkg::SEL_DATA:
            begin
                rd_mux = core_rd_data_i & lane_mask(ecc_byte_i);
                rd_oe  = lane_mask(ecc_byte_i);
            end
            task_file_pkg::SEL_ERR_FEAT: rd_mux[7:0] = fault;
            task_file_pkg::SEL_COUNT:    rd_mux[7:0] = count;
            task_file_pkg::SEL_SECTOR:   rd_mux[7:0] = sector;
            task_file_pkg::SEL_CYL_LO:   rd_mux[7:0] = cyl_lo;
            task_file_pkg::SEL_CYL_HI:   rd_mux[7:0] = cyl_hi;
            task_file_pkg::SEL_UNIT:     rd_mux[7:0] = unit_head;
            task_file_pkg::SEL_STAT_CMD,
            task_file_pkg::SEL_ALT_CTRL: rd_mux[7:0] = core_status_i;
            task_file_pkg::SEL_ADDR_RPT:
            begin
                rd_mux[7:0] = {1'b0, write_gate_n_i,
                               ~unit_head[3:0],
                               ~(unit_head[4] & selected),
                               ~(~unit_head[4] & selected)};
                rd_oe = 16'h007f;
            end
            default: rd_oe = 16'h0000;
        endcase
        if (core_status_i[task_file_pkg::BUSY_POS] && rd_oe != 16'h0000)
        begin
            rd_mux = {8'h00, core_status_i};
            rd_oe  = 16'h00ff;
        end
        if (!rd_strobe_i)
        begin
            rd_oe = 16'h0000;
        end
    end

    assign host_data_o    = rd_mux;
    assign host_data_oe_o = rd_oe;
    assign host_intrq_o   = irq_pend && selected
                          && !ctrl[task_file_pkg::INT_DISABLE_POS];
    assign cmd_start_o    = start;
    assign cmd_code_o     = command;
    assign cmd_param_o    = feature;
    assign sector_total_o = (count == 8'h00) ? 9'h100 : {1'b0, count};
    assign linear_mode_o  = unit_head[task_file_pkg::LINEAR_POS];
    assign soft_reset_o   = dev_reset;
    assign core_wr_data_o = wdata;
    assign core_wr_o      = wstb;
    assign core_rd_o      = rd_strobe_i && sel == task_file_pkg::SEL_DATA
                          && data_ok;

////////////////////////////////////////////////////////////////////////

    sequence s_cmd_write;
        wr_strobe_i && sel == task_file_pkg::SEL_STAT_CMD && !dev_reset;
    endsequence

    a_cmd_starts: assert property (@(posedge clock_i) disable iff (rst_i)
        s_cmd_write |=> cmd_start_o && cmd_code_o == $past(host_data_i[7:0]))
        else $error("command write did not start");
    a_alt_no_ack: assert property (@(posedge clock_i) disable iff (dev_reset)
        rd_strobe_i && sel == task_file_pkg::SEL_ALT_CTRL && irq_pend
        && !cmd_done_i |=> irq_pend)
        else $error("alternate status cleared interrupt");
    a_status_ack: assert property (@(posedge clock_i) disable iff (dev_reset)
        rd_strobe_i && sel == task_file_pkg::SEL_STAT_CMD && !core_irq_i
        |=> !irq_pend)
        else $error("status read did not acknowledge");
    a_intrq_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        host_intrq_o |-> !ctrl[task_file_pkg::INT_DISABLE_POS] && selected)
        else $error("interrupt driven while disabled");
    a_soft_reset: assert property (@(posedge clock_i) disable iff (rst_i)
        ctrl[task_file_pkg::SOFT_RESET_POS] |=> count == task_file_pkg::RST_COUNT
        && unit_head == task_file_pkg::RST_UNIT && !cmd_start_o)
        else $error("soft reset not held");
    a_end_update: assert property (@(posedge clock_i) disable iff (dev_reset)
        cmd_done_i && !wr_strobe_i |=> cyl_hi == $past(end_cyl_hi_i)
        && cyl_lo == $past(end_cyl_lo_i) && sector == $past(end_sector_i)
        && count == $past(end_remaining_i))
        else $error("position not updated at command end");
    a_fixed_ones: assert property (@(posedge clock_i) disable iff (rst_i)
        unit_head[7] && unit_head[5])
        else $error("unit/head fixed bits not one");
    a_fault_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        cmd_done_i && !diag_done_i && !dev_reset |=> fault[5] == 1'b0
        && fault[3] == 1'b0)
        else $error("error bits 5 or 3 set");
    a_hiz_bit: assert property (@(posedge clock_i) disable iff (rst_i)
        sel == task_file_pkg::SEL_ADDR_RPT && !core_status_i[7]
        |-> !host_data_oe_o[7] && host_data_o[6] == write_gate_n_i)
        else $error("address report bit 7 driven");
    a_zero_count: assert property (@(posedge clock_i) disable iff (rst_i)
        count == 8'h00 |-> sector_total_o == 9'h100)
        else $error("zero count not 256");

    sequence s_sector_write;
        wr_strobe_i && sel == task_file_pkg::SEL_SECTOR;
    endsequence

    sequence s_data_read;
        rd_strobe_i && sel == task_file_pkg::SEL_DATA
        && !core_status_i[task_file_pkg::BUSY_POS];
    endsequence

    // Host writes beat a command end that falls in the same cycle
    a_write_lands: assert property (@(posedge clock_i)
        disable iff (dev_reset)
        s_sector_write |=> sector == $past(host_data_i[7:0]))
        else $error("sector write did not land");
    a_word_lanes: assert property (@(posedge clock_i)
        disable iff (rst_i)
        s_data_read ##0 !ecc_byte_i |-> host_data_oe_o == 16'hffff
        && host_data_o == core_rd_data_i)
        else $error("data word not on all lanes");
    a_ecc_lane: assert property (@(posedge clock_i)
        disable iff (rst_i)
        s_data_read ##0 ecc_byte_i |-> host_data_oe_o == 16'h00ff
        && host_data_o[15:8] == 8'h00)
        else $error("ECC byte not on low lane");
    a_rd_request: assert property (@(posedge clock_i)
        disable iff (rst_i)
        core_rd_o |-> rd_strobe_i && core_status_i[task_file_pkg::DRQ_POS])
        else $error("data read without data request");
    a_head_update: assert property (@(posedge clock_i)
        disable iff (dev_reset)
        cmd_done_i && !wr_strobe_i |=> unit_head[3:0] == $past(end_head_i))
        else $error("head bits not updated at command end");
    a_diag_code: assert property (@(posedge clock_i)
        disable iff (dev_reset)
        diag_done_i |=> fault == $past(end_fault_i))
        else $error("diagnostic code not loaded");
    a_ctrl_kept: assert property (@(posedge clock_i)
        disable iff (rst_i)
        ctrl[task_file_pkg::SOFT_RESET_POS] && !wr_strobe_i
        |=> ctrl[task_file_pkg::SOFT_RESET_POS])
        else $error("soft reset bit lost while held");
    a_busy_status: assert property (@(posedge clock_i)
        disable iff (rst_i)
        core_status_i[task_file_pkg::BUSY_POS] && host_data_oe_o != 16'h0000
        |-> host_data_o == {8'h00, core_status_i})
        else $error("busy read did not return status");

endmodule

//--- tb/host_port_model.sv
/*
 * Host side of the task-file port: chip selects, address, strobes, data.
 * Assumes the device samples the port on the rising edge of clock_i.
 */
`timescale 1ns/1ps
module host_port_model
(
    // Clock
    input  wire logic        clock_i,
    // Register port toward the device
    output logic             cs0_n_o,
    output logic             cs1_n_o,
    output logic [2:0]       da_o,
    output logic             rd_strobe_o,
    output logic             wr_strobe_o,
    output logic [15:0]      data_o,
    input  wire logic [15:0] data_i,
    input  wire logic [15:0] data_oe_i
);
    ////////////////////////////////////////
    initial
    begin
        {cs0_n_o, cs1_n_o, da_o} = 5'h18;
        rd_strobe_o = 1'b0;
        wr_strobe_o = 1'b0;
        data_o = 16'h5a5a;
    end

    // One strobe cycle; select and data held across the sampling edge
    task automatic access(input logic [4:0] sel, input logic wr,
                          input logic [15:0] wd, output logic [15:0] rd,
                          output logic [15:0] oe);
        @(negedge clock_i);
        {cs0_n_o, cs1_n_o, da_o} = sel;
        wr_strobe_o = wr;
        rd_strobe_o = !wr;
        data_o = wr ? wd : ~data_o;
        #2;
        rd = data_i;
        oe = data_oe_i;
        @(negedge clock_i);
        wr_strobe_o = 1'b0;
        rd_strobe_o = 1'b0;
        {cs0_n_o, cs1_n_o, da_o} = 5'h18;
        // A released bus must not keep showing the last word
        data_o = ~data_o;
    endtask
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench for the task-file register bank.
 * Assumes the host model above and a drive core played by this bench.
 */
`timescale 1ns/1ps
module tb_top;
    ////////////////////////////////////////
    logic        clock_i = 1'b0, rst_i = 1'b1;
    logic        cs0_n_i, cs1_n_i, rd_strobe_i, wr_strobe_i, host_intrq_o;
    logic [2:0]  da_i;
    logic [15:0] host_data_i, host_data_o, host_data_oe_o;
    logic [15:0] core_rd_data_i, core_wr_data_o, rdat, roe;
    logic        unit_id_i, core_irq_i, write_gate_n_i, cmd_start_o;
    logic        linear_mode_o, soft_reset_o, cmd_done_i, diag_done_i;
    logic        ecc_byte_i, core_wr_o, core_rd_o;
    logic [7:0]  core_status_i, cmd_code_o, cmd_param_o, end_fault_i;
    logic [7:0]  end_remaining_i, end_sector_i, end_cyl_lo_i, end_cyl_hi_i;
    logic [8:0]  sector_total_o;
    logic [3:0]  end_head_i;
    int          fail_count = 0, checks_done = 0;
    logic [15:0] rd_pulses = 16'h0000;

    always #4 clock_i = ~clock_i;

    // Counts data reads passed to the core
    always @(posedge clock_i)
        if (core_rd_o === 1'b1)
            rd_pulses <= rd_pulses + 16'h0001;

    host_port_model host_port_model_inst (.clock_i, .cs0_n_o(cs0_n_i),
        .cs1_n_o(cs1_n_i), .da_o(da_i), .rd_strobe_o(rd_strobe_i),
        .wr_strobe_o(wr_strobe_i), .data_o(host_data_i),
        .data_i(host_data_o), .data_oe_i(host_data_oe_o));

    disk_task_file_registers disk_task_file_registers_inst (.clock_i,
        .rst_i, .cs0_n_i, .cs1_n_i, .da_i, .rd_strobe_i, .wr_strobe_i,
        .host_data_i, .host_data_o, .host_data_oe_o, .host_intrq_o,
        .unit_id_i, .core_status_i, .core_irq_i, .write_gate_n_i,
        .cmd_start_o, .cmd_code_o, .cmd_param_o, .sector_total_o,
        .linear_mode_o, .soft_reset_o, .cmd_done_i, .diag_done_i,
        .end_fault_i, .end_remaining_i, .end_sector_i, .end_cyl_lo_i,
        .end_cyl_hi_i, .end_head_i, .ecc_byte_i, .core_rd_data_i,
        .core_wr_data_o, .core_wr_o, .core_rd_o);

    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic step;
        @(negedge clock_i);
    endtask

    task automatic acc(input logic [4:0] s, input logic w,
                       input logic [15:0] d);
        host_port_model_inst.access(s, w, d, rdat, roe);
    endtask

    task automatic rd8(input logic [4:0] s, input logic [7:0] e);
        acc(s, 1'b0, 16'h0000);
        chk({8'h00, rdat[7:0]}, {8'h00, e});
    endtask

    task automatic stop_test;
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////
    task automatic params_and_command;
        acc(task_file_pkg::SEL_COUNT, 1'b1, 16'h0000);
        acc(task_file_pkg::SEL_ERR_FEAT, 1'b1, 16'h0003);
        acc(task_file_pkg::SEL_SECTOR, 1'b1, 16'h0021);
        acc(task_file_pkg::SEL_UNIT, 1'b1, 16'h0045);
        rd8(task_file_pkg::SEL_SECTOR, 8'h21);
        chk({7'h00, sector_total_o}, 16'h0100);
        rd8(task_file_pkg::SEL_UNIT, 8'he5);
        chk({15'h0000, linear_mode_o}, 16'h0001);
        acc(task_file_pkg::SEL_STAT_CMD, 1'b1, 16'h0020);
        chk({7'h00, cmd_start_o, cmd_code_o}, 16'h0120);
        chk({8'h00, cmd_param_o}, 16'h0003);
        step;
        chk({15'h0000, cmd_start_o}, 16'h0000);
    endtask

    task automatic command_end;
        {end_fault_i, end_remaining_i, end_sector_i} = 24'hff073c;
        {end_cyl_lo_i, end_cyl_hi_i, end_head_i} = 20'h12349;
        cmd_done_i = 1'b1;
        step;
        cmd_done_i = 1'b0;
        rd8(task_file_pkg::SEL_ERR_FEAT, 8'hd7);
        rd8(task_file_pkg::SEL_COUNT, 8'h07);
        rd8(task_file_pkg::SEL_SECTOR, 8'h3c);
        rd8(task_file_pkg::SEL_CYL_LO, 8'h12);
        rd8(task_file_pkg::SEL_CYL_HI, 8'h34);
        rd8(task_file_pkg::SEL_UNIT, 8'he9);
    endtask

    task automatic address_and_interrupt;
        write_gate_n_i = 1'b0;
        rd8(task_file_pkg::SEL_ADDR_RPT, 8'h1a);
        chk(roe, 16'h007f);
        write_gate_n_i = 1'b1;
        core_irq_i = 1'b1;
        step;
        core_irq_i = 1'b0;
        chk({15'h0000, host_intrq_o}, 16'h0001);
        rd8(task_file_pkg::SEL_ALT_CTRL, 8'h50);
        chk({15'h0000, host_intrq_o}, 16'h0001);
        acc(task_file_pkg::SEL_ALT_CTRL, 1'b1, 16'h0002);
        chk({15'h0000, host_intrq_o}, 16'h0000);
        acc(task_file_pkg::SEL_ALT_CTRL, 1'b1, 16'h0000);
        acc(task_file_pkg::SEL_UNIT, 1'b1, 16'h0059);
        chk({15'h0000, host_intrq_o}, 16'h0000);
        rd8(task_file_pkg::SEL_ADDR_RPT, 8'h5b);
        unit_id_i = 1'b1;
        rd8(task_file_pkg::SEL_ADDR_RPT, 8'h59);
        chk({15'h0000, host_intrq_o}, 16'h0001);
        unit_id_i = 1'b0;
        acc(task_file_pkg::SEL_UNIT, 1'b1, 16'h0049);
        chk({15'h0000, host_intrq_o}, 16'h0001);
        rd8(task_file_pkg::SEL_STAT_CMD, 8'h50);
        chk(roe, 16'h00ff);
        chk({15'h0000, host_intrq_o}, 16'h0000);
        acc(5'h10, 1'b0, 16'h0000);
        chk(roe, 16'h0000);
        acc(5'h07, 1'b0, 16'h0000);
        chk(roe, 16'h0000);
    endtask

    task automatic data_port;
        core_status_i = 8'h58;
        acc(task_file_pkg::SEL_DATA, 1'b0, 16'h0000);
        chk(rdat, 16'hbeef);
        chk(roe, 16'hffff);
        ecc_byte_i = 1'b1;
        acc(task_file_pkg::SEL_DATA, 1'b0, 16'h0000);
        chk({8'h00, rdat[7:0]}, 16'h00ef);
        chk(roe, 16'h00ff);
        ecc_byte_i = 1'b0;
        core_status_i = 8'h50;
        acc(task_file_pkg::SEL_DATA, 1'b0, 16'h0000);
        chk(rd_pulses, 16'h0002);
        acc(task_file_pkg::SEL_DATA, 1'b1, 16'hcafe);
        chk(core_wr_data_o, 16'hcafe);
        chk({15'h0000, core_wr_o}, 16'h0001);
        core_status_i = 8'h80;
        rd8(task_file_pkg::SEL_COUNT, 8'h80);
        core_status_i = 8'h50;
    endtask

    task automatic soft_reset_and_diag;
        acc(task_file_pkg::SEL_COUNT, 1'b1, 16'h0033);
        acc(task_file_pkg::SEL_ALT_CTRL, 1'b1, 16'h0004);
        chk({15'h0000, soft_reset_o}, 16'h0001);
        acc(task_file_pkg::SEL_COUNT, 1'b1, 16'h0044);
        repeat (task_file_pkg::SOFT_RESET_BIT_HOLD_CYC) step;
        acc(task_file_pkg::SEL_ALT_CTRL, 1'b1, 16'h0000);
        chk({15'h0000, soft_reset_o}, 16'h0000);
        rd8(task_file_pkg::SEL_COUNT, 8'h01);
        rd8(task_file_pkg::SEL_UNIT, 8'ha0);
        rd8(task_file_pkg::SEL_ERR_FEAT, 8'h01);
        end_fault_i = 8'h8c;
        diag_done_i = 1'b1;
        step;
        diag_done_i = 1'b0;
        rd8(task_file_pkg::SEL_ERR_FEAT, 8'h8c);
    endtask

    ////////////////////////////////////////
    initial
    begin
        {unit_id_i, core_irq_i, write_gate_n_i, ecc_byte_i} = 4'h2;
        {cmd_done_i, diag_done_i, end_head_i} = 6'h00;
        {end_fault_i, end_remaining_i, end_sector_i} = 24'h000000;
        {end_cyl_lo_i, end_cyl_hi_i, core_status_i} = 24'h000050;
        core_rd_data_i = 16'hbeef;
        repeat (3) step;
        rst_i = 1'b0;
        rd8(task_file_pkg::SEL_ERR_FEAT, 8'h01);
        rd8(task_file_pkg::SEL_SECTOR, 8'h01);
        params_and_command;
        command_end;
        address_and_interrupt;
        data_port;
        soft_reset_and_diag;
        stop_test;
    end

    // The soft-reset hold dominates the run; allow about four times the whole run
    initial
    begin
        repeat (3000) @(posedge clock_i);
        fail_count++;
        stop_test;
    end
endmodule
